// File: verilog/rcdp_top.sv
// Contract
// - Only words with some rank select low are parity checked.
// - Fault output goes low on third edge after the bad word.
// - Fault releases on fifth cycle after the last bad word.
// - Fault stays low at least two cycles unless reset or clock stop comes first.
// - Clock enable, rank select and termination inputs excluded from parity.
// - Control word writes are parity checked; bad ones are dropped.
// - Stopped clock floats all outputs but holds clock enables low.
// - Clock stop keeps control words; only reset clears them.
// - Float option with all selects high floats gated outputs.
// - Reset overrides power saving: float, fault high, enables low.
// - During reset selects, termination, data, clocks float.
// - After reset selects drive high, termination low, then follow.
// - Reset returns control words to zero, two vendor words excepted.
`timescale 1ns/1ps
`default_nettype none
`include "rcdp_defines.svh"
module rcdp_top #(
	parameter int                NCS          = 2,
	parameter int                AW           = 22,
	parameter rcdp_pkg::rcdp_cw_t VENDOR_A_DEF = 4'h0, // arbitrary value
	parameter rcdp_pkg::rcdp_cw_t VENDOR_B_DEF = 4'h0  // arbitrary value
) (
	input  wire logic           clk,
	input  wire logic           resetn,
	input  wire logic           clk_halt_in,
	input  wire logic [NCS-1:0] rank_select_in_n,
	input  wire logic           clk_en_in0,
	input  wire logic           clk_en_in1,
	input  wire logic           termination_ctl_in0,
	input  wire logic           termination_ctl_in1,
	input  wire logic [AW-1:0]  cmd_addr_in,
	input  wire logic           parity_bit_in,
	output logic      [AW-1:0]  registered_outputs,
	output logic                registered_oe,
	output logic      [NCS-1:0] rank_select_out_n,
	output logic                rank_select_out_oe,
	output logic      [1:0]     termination_ctl_out,
	output logic                termination_ctl_oe,
	output logic                clk_en_out_a0,
	output logic                clk_en_out_a1,
	output logic                clk_en_out_b0,
	output logic                clk_en_out_b1,
	output logic                clk_out_oe,
	output logic                input_bus_termination,
	output logic                parity_fault_out_n,
	output logic                parity_fault_oe
);
	import rcdp_pkg::*;

	localparam int CWN = `RCDP_CW_COUNT;
	localparam int CWW = `RCDP_CW_WIDTH;
	localparam int CAW = $clog2(CWN);

	logic [AW-1:0]      word_d;
	logic               acc_d;
	logic               mismatch;
	logic               err_late;
	logic               cw_we;
	logic [CAW-1:0]     cw_addr;
	rcdp_cw_t           cw_data;
	rcdp_cw_t           cw [CWN];
	logic [CWN*CWW-1:0] cw_flat;
	logic               float_en;
	logic               all_desel;
	rcdp_cnt_t          fault_cnt;
	logic               next_fault_oe;

	// access decode on the incoming word
	assign all_desel = &rank_select_in_n;

	rcdp_parity_chk #(
		.AW(AW)
	) u_chk (
		.clk          (clk),
		.resetn       (resetn),
		.word_in      (cmd_addr_in),
		.qual_in      (~all_desel),
		.acc_in       (~|rank_select_in_n),
		.parity_bit_in(parity_bit_in),
		.word_d       (word_d),
		.acc_d        (acc_d),
		.mismatch     (mismatch),
		.err_late     (err_late)
	);

	// control word write commits only with good parity, never while halted
	assign cw_we   = acc_d & ~mismatch & ~clk_halt_in;
	assign cw_addr = word_d[`RCDP_CW_ADDR_LSB +: CAW];
	assign cw_data = word_d[`RCDP_CW_DATA_LSB +: CWW];

	// one storage word per control word
	for (genvar g = 0; g < CWN; g++)
	begin : g_cw
		localparam rcdp_cw_t DEF = (g == `RCDP_CW_VENDOR_A) ? VENDOR_A_DEF :
			(g == `RCDP_CW_VENDOR_B) ? VENDOR_B_DEF : `RCDP_CW_DEFAULT;
		always_ff @(posedge clk or negedge resetn)
		begin
			if (!resetn)
				cw[g] <= DEF;
			else if (cw_we && cw_addr == CAW'(g))
				cw[g] <= cw_data;
		end
		assign cw_flat[g*CWW +: CWW] = cw[g];
	end

	assign float_en = cw[`RCDP_CW_FLOAT_WORD][`RCDP_CW_FLOAT_BIT];

	// fault hold: retimed by every new error, cleared by halt
	always_comb
	begin
		next_fault_oe = 1'b0;
		if (clk_halt_in)
			next_fault_oe = 1'b0;
		else if (err_late)
			next_fault_oe = 1'b1;
		else if (fault_cnt != '0)
			next_fault_oe = parity_fault_oe;
	end

	// open-drain fault pin and its hold counter
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			parity_fault_oe    <= 1'b0;
			parity_fault_out_n <= 1'b1;
			fault_cnt          <= '0;
		end
		else
		begin
			parity_fault_oe    <= next_fault_oe;
			parity_fault_out_n <= ~next_fault_oe;
			if (clk_halt_in)
				fault_cnt <= '0;
			else if (err_late)
				fault_cnt <= rcdp_cnt_t'(`RCDP_FAULT_LOW_CYC - 1);
			else if (fault_cnt != '0)
				fault_cnt <= fault_cnt - 2'h1;
		end
	end

	// registered copies of the inputs
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			registered_outputs  <= '0;
			rank_select_out_n   <= '1;
			termination_ctl_out <= 2'h0;
			clk_en_out_a0       <= 1'b0;
			clk_en_out_a1       <= 1'b0;
			clk_en_out_b0       <= 1'b0;
			clk_en_out_b1       <= 1'b0;
		end
		else if (clk_halt_in)
		begin
			clk_en_out_a0 <= 1'b0;
			clk_en_out_a1 <= 1'b0;
			clk_en_out_b0 <= 1'b0;
			clk_en_out_b1 <= 1'b0;
		end
		else
		begin
			registered_outputs  <= cmd_addr_in;
			rank_select_out_n   <= rank_select_in_n;
			termination_ctl_out <= {termination_ctl_in1, termination_ctl_in0};
			clk_en_out_a0       <= clk_en_in0;
			clk_en_out_a1       <= clk_en_in1;
			clk_en_out_b0       <= clk_en_in0;
			clk_en_out_b1       <= clk_en_in1;
		end
	end

	// output enables and input termination
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			registered_oe         <= 1'b0;
			rank_select_out_oe    <= 1'b0;
			termination_ctl_oe    <= 1'b0;
			clk_out_oe            <= 1'b0;
			input_bus_termination <= 1'b0;
		end
		else if (clk_halt_in)
		begin
			registered_oe         <= 1'b0;
			rank_select_out_oe    <= 1'b0;
			termination_ctl_oe    <= 1'b0;
			clk_out_oe            <= 1'b0;
			input_bus_termination <= 1'b0;
		end
		else
		begin
			registered_oe         <= ~(float_en & all_desel);
			rank_select_out_oe    <= 1'b1;
			termination_ctl_oe    <= 1'b1;
			clk_out_oe            <= 1'b1;
			input_bus_termination <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_deselect_unchecked;
		all_desel |=> !mismatch;
	endproperty
	a_deselect_unchecked: assert property (p_deselect_unchecked)
		else $error("deselected word was parity checked");

	property p_fault_third_edge;
		mismatch ##1 !clk_halt_in [*3] |-> parity_fault_oe;
	endproperty
	a_fault_third_edge: assert property (p_fault_third_edge)
		else $error("fault not driven on third edge");

	property p_fault_release;
		$fell(parity_fault_oe) && !$past(clk_halt_in)
			|-> !$past(err_late) && !$past(err_late, 2);
	endproperty
	a_fault_release: assert property (p_fault_release)
		else $error("fault released too early");

	property p_fault_min_low;
		$rose(parity_fault_oe) && !clk_halt_in |=> parity_fault_oe;
	endproperty
	a_fault_min_low: assert property (p_fault_min_low)
		else $error("fault low for under two cycles");

	property p_bad_cw_dropped;
		mismatch && acc_d |=> $stable(cw_flat);
	endproperty
	a_bad_cw_dropped: assert property (p_bad_cw_dropped)
		else $error("control word written with bad parity");

	property p_halt_outputs;
		clk_halt_in |=> !registered_oe && !rank_select_out_oe &&
			!termination_ctl_oe && !parity_fault_oe && !clk_out_oe &&
			!clk_en_out_a0 && !clk_en_out_a1 &&
			!clk_en_out_b0 && !clk_en_out_b1;
	endproperty
	a_halt_outputs: assert property (p_halt_outputs)
		else $error("outputs not parked during halt");

	property p_halt_keeps_cw;
		clk_halt_in |=> $stable(cw_flat);
	endproperty
	a_halt_keeps_cw: assert property (p_halt_keeps_cw)
		else $error("control words changed during halt");

	property p_float_gate;
		float_en && all_desel && !clk_halt_in |=> !registered_oe;
	endproperty
	a_float_gate: assert property (p_float_gate)
		else $error("gated outputs not floated");

	property p_reset_exit;
		$rose(resetn) |-> (&rank_select_out_n) &&
			termination_ctl_out == 2'h0;
	endproperty
	a_reset_exit: assert property (p_reset_exit)
		else $error("wrong output state after reset release");

	c_single_fault: cover property ($rose(parity_fault_oe));
	c_back_to_back: cover property (err_late ##1 err_late);
	c_cw_write: cover property (cw_we);
	c_float: cover property (float_en && all_desel ##1 !registered_oe);
endmodule // rcdp_top
`default_nettype wire

// File: shared/rcdp_defines.svh
`ifndef RCDP_DEFINES_SVH
`define RCDP_DEFINES_SVH

// control word store layout
`define RCDP_CW_COUNT       16
`define RCDP_CW_WIDTH       4
`define RCDP_CW_ADDR_LSB    0
`define RCDP_CW_DATA_LSB    4
`define RCDP_CW_DEFAULT     4'h0
`define RCDP_CW_VENDOR_A    6
`define RCDP_CW_VENDOR_B    7

// output float option location
`define RCDP_CW_FLOAT_WORD  1
`define RCDP_CW_FLOAT_BIT   0

// fault output minimum low time in clock cycles
`define RCDP_FAULT_LOW_CYC  2

`endif

// File: shared/rcdp_pkg.sv
package rcdp_pkg;
	typedef logic [3:0] rcdp_cw_t;
	typedef logic [1:0] rcdp_cnt_t;
endpackage

// File: verilog/rcdp_parity_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rcdp_parity_chk #(
	parameter int AW = 22
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic [AW-1:0] word_in,
	input  wire logic          qual_in,
	input  wire logic          acc_in,
	input  wire logic          parity_bit_in,
	output logic      [AW-1:0] word_d,
	output logic               acc_d,
	output logic               mismatch,
	output logic               err_late
);
	logic qual_d;
	logic err_early;

	// hold word one cycle to meet its late parity bit
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			word_d <= '0;
			qual_d <= 1'b0;
			acc_d  <= 1'b0;
		end
		else
		begin
			word_d <= word_in;
			qual_d <= qual_in;
			acc_d  <= acc_in;
		end
	end

	// even parity over covered bits, selected words only
	assign mismatch = qual_d & (^word_d ^ parity_bit_in);

	// two stages so the fault shows on the third edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			err_early <= 1'b0;
			err_late  <= 1'b0;
		end
		else
		begin
			err_early <= mismatch;
			err_late  <= err_early;
		end
	end
endmodule // rcdp_parity_chk
`default_nettype wire

// File: verif/rcdp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcdp_ctl_model (
	input  wire logic        clk,
	input  wire logic [21:0] cmd_addr_in,
	input  wire logic        flip,
	output logic             parity_bit_in
);
	// even parity of the word, presented one edge after it
	always_ff @(posedge clk)
	begin
		parity_bit_in <= ^cmd_addr_in ^ flip;
	end
endmodule // rcdp_ctl_model
`default_nettype wire

// File: verif/rcdp_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin \
		check_count++; \
		if ((a) !== (b)) \
		begin \
			miscompares++; \
			$display("wrong value at %0t: got %h want %h", $time, a, b); \
		end \
	end
module testbench;
	logic        clk, resetn, clk_halt_in, flip, parity_bit_in;
	logic [1:0]  rank_select_in_n, rank_select_out_n, termination_ctl_out;
	logic        clk_en_in0, clk_en_in1, termination_ctl_in0;
	logic        termination_ctl_in1;
	logic [21:0] cmd_addr_in, registered_outputs;
	logic        registered_oe, rank_select_out_oe, termination_ctl_oe;
	logic        clk_en_out_a0, clk_en_out_a1, clk_en_out_b0;
	logic        clk_en_out_b1, clk_out_oe, input_bus_termination;
	logic        parity_fault_out_n, parity_fault_oe;
	int          miscompares, check_count;

	rcdp_top u_dut (
		.clk                  (clk),
		.resetn               (resetn),
		.clk_halt_in          (clk_halt_in),
		.rank_select_in_n     (rank_select_in_n),
		.clk_en_in0           (clk_en_in0),
		.clk_en_in1           (clk_en_in1),
		.termination_ctl_in0  (termination_ctl_in0),
		.termination_ctl_in1  (termination_ctl_in1),
		.cmd_addr_in          (cmd_addr_in),
		.parity_bit_in        (parity_bit_in),
		.registered_outputs   (registered_outputs),
		.registered_oe        (registered_oe),
		.rank_select_out_n    (rank_select_out_n),
		.rank_select_out_oe   (rank_select_out_oe),
		.termination_ctl_out  (termination_ctl_out),
		.termination_ctl_oe   (termination_ctl_oe),
		.clk_en_out_a0        (clk_en_out_a0),
		.clk_en_out_a1        (clk_en_out_a1),
		.clk_en_out_b0        (clk_en_out_b0),
		.clk_en_out_b1        (clk_en_out_b1),
		.clk_out_oe           (clk_out_oe),
		.input_bus_termination(input_bus_termination),
		.parity_fault_out_n   (parity_fault_out_n),
		.parity_fault_oe      (parity_fault_oe)
	);

	rcdp_ctl_model u_ctl (
		.clk          (clk),
		.cmd_addr_in  (cmd_addr_in),
		.flip         (flip),
		.parity_bit_in(parity_bit_in)
	);

	// 8 ns clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// put one word, its selects and its parity flip on the inputs
	task drive(input logic [21:0] w, input logic [1:0] s, input logic f);
		cmd_addr_in = w;
		rank_select_in_n = s;
		flip = f;
	endtask

	// one word for one edge, then idle with all selects high
	task send(input logic [21:0] w, input logic [1:0] s, input logic f);
		drive(w, s, f);
		tick(1);
		drive(22'h000000, 2'b11, 1'b0);
	endtask

	// outputs parked while reset is low, selects high at release
	task t_reset_state(input int hold);
		resetn = 1'b0;
		// clock enables low across the release
		clk_en_in0 = 1'b0;
		clk_en_in1 = 1'b0;
		tick(hold);
		`CHK(registered_oe, 1'b0)
		`CHK(parity_fault_out_n, 1'b1)
		`CHK(parity_fault_oe, 1'b0)
		`CHK({clk_en_out_a0, clk_en_out_a1}, 2'h0)
		`CHK({clk_en_out_b0, clk_en_out_b1}, 2'h0)
		`CHK(input_bus_termination, 1'b0)
		`CHK({rank_select_out_oe, clk_out_oe}, 2'b00)
		`CHK(termination_ctl_oe, 1'b0)
		resetn = 1'b1;
		#3 `CHK(rank_select_out_n, 2'b11)
		`CHK(termination_ctl_out, 2'b00)
		tick(2);
		`CHK(rank_select_out_oe, 1'b1)
		`CHK({termination_ctl_oe, clk_out_oe}, 2'h3)
		`CHK(input_bus_termination, 1'b1)
		$display("reset state done");
	endtask

	// one bad word, then a back to back pair
	task t_fault_timing;
		send(22'h12345, 2'b10, 1'b1);
		tick(2);
		`CHK(parity_fault_oe, 1'b0)
		tick(1);
		`CHK(parity_fault_out_n, 1'b0)
		tick(1);
		`CHK(parity_fault_oe, 1'b1)
		tick(1);
		`CHK(parity_fault_oe, 1'b0)
		drive(22'h00001, 2'b01, 1'b1);
		tick(1);
		send(22'h3fffff, 2'b10, 1'b1);
		tick(4);
		`CHK(parity_fault_oe, 1'b1)
		tick(1);
		`CHK(parity_fault_oe, 1'b0)
		$display("fault timing done");
	endtask

	// deselected bad word and varying side inputs never flag
	task t_no_fault;
		drive(22'h0f0f0, 2'b11, 1'b1);
		clk_en_in0 = 1'b1;
		clk_en_in1 = 1'b1;
		termination_ctl_in1 = 1'b1;
		tick(1);
		send(22'h2a5a5a, 2'b10, 1'b0);
		`CHK(registered_outputs, 22'h2a5a5a)
		`CHK(rank_select_out_n, 2'b10)
		`CHK({clk_en_out_a0, clk_en_out_b0}, 2'b11)
		`CHK({clk_en_out_a1, clk_en_out_b1}, 2'h3)
		`CHK(termination_ctl_out, 2'b10)
		repeat (5)
		begin
			tick(1);
			`CHK(parity_fault_oe, 1'b0)
		end
		$display("no fault done");
	endtask

	// bad write dropped, good write sets float option
	task t_float;
		send(22'h00011, 2'b00, 1'b1);
		tick(6);
		`CHK(registered_oe, 1'b1)
		send(22'h00011, 2'b00, 1'b0);
		tick(2);
		`CHK(registered_oe, 1'b0)
		rank_select_in_n = 2'b01;
		tick(1);
		`CHK(registered_oe, 1'b1)
		rank_select_in_n = 2'b11;
		tick(1);
		$display("float done");
	endtask

	// halted clock parks outputs, float option survives
	task t_halt;
		clk_halt_in = 1'b1;
		tick(1);
		`CHK({clk_en_out_a0, clk_en_out_a1}, 2'h0)
		`CHK({clk_en_out_b0, clk_en_out_b1}, 2'h0)
		clk_en_in0 = 1'b0;
		clk_en_in1 = 1'b0;
		tick(1);
		`CHK({registered_oe, rank_select_out_oe, clk_out_oe}, 3'b000)
		`CHK({termination_ctl_oe, input_bus_termination}, 2'h0)
		`CHK(parity_fault_oe, 1'b0)
		clk_halt_in = 1'b0;
		tick(4);
		`CHK(rank_select_out_oe, 1'b1)
		`CHK(registered_oe, 1'b0)
		// enables high so the reset below has something to clear
		clk_en_in0 = 1'b1;
		clk_en_in1 = 1'b1;
		tick(1);
		t_reset_state(13);
		tick(1);
		`CHK(registered_oe, 1'b1)
		$display("halt done");
	endtask

	task close_out;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog
	initial
	begin
		#4000;
		miscompares++;
		close_out;
	end

	// main sequence
	initial
	begin
		miscompares = 0;
		check_count = 0;
		clk_halt_in = 1'b0;
		flip = 1'b0;
		rank_select_in_n = 2'b11;
		cmd_addr_in = 22'h000000;
		{termination_ctl_in0, termination_ctl_in1} = 2'b00;
		t_reset_state(3);
		t_fault_timing;
		t_no_fault;
		t_float;
		t_halt;
		close_out;
	end
endmodule // testbench
`default_nettype wire
